/* File: hw/act_defs.svh */
// Purpose: Constants for the ADC computation and threshold unit
// Assumes: APB byte addresses, 32-bit data, one register per word
// Notes: Field positions are bit indices inside each register
`ifndef ACT_DEFS_SVH
`define ACT_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ACT_OFF_CTRL0 8'h00
`define ACT_OFF_CTRL1 8'h04
`define ACT_OFF_COMP 8'h08
`define ACT_OFF_THRC 8'h0C
`define ACT_OFF_STAT 8'h10
`define ACT_OFF_RES 8'h14
`define ACT_OFF_PREV 8'h18
`define ACT_OFF_ACC 8'h1C
`define ACT_OFF_FLTR 8'h20
`define ACT_OFF_STPT 8'h24
`define ACT_OFF_UTH 8'h28
`define ACT_OFF_LTH 8'h2C
`define ACT_OFF_ERR 8'h30
`define ACT_OFF_RPT 8'h34
`define ACT_OFF_CNT 8'h38
`define ACT_OFF_CLK 8'h3C
`define ACT_OFF_TIF 8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACT_B_ON 7
`define ACT_B_CONT 6
`define ACT_B_CS 4
`define ACT_B_FRM 2
`define ACT_B_GO 0
`define ACT_B_PPOL 7
`define ACT_B_IPEN 6
`define ACT_B_GPOL 5
`define ACT_B_DSEN 0
`define ACT_B_PSIS 7
`define ACT_B_ACLR 3
`define ACT_B_SOI 3
`define ACT_B_MATH 4
`define ACT_B_TIF 0

// ----------------------------------------------------------------
// Modes, error selections, stage codes, reset values
// ----------------------------------------------------------------
`define ACT_MD_BASIC 3'h0
`define ACT_MD_ACC 3'h1
`define ACT_MD_AVG 3'h2
`define ACT_MD_BURST 3'h3
`define ACT_MD_LPF 3'h4
`define ACT_CALC_DERIV 3'h0
`define ACT_CALC_RSTPT 3'h1
`define ACT_CALC_RFLT 3'h2
`define ACT_CALC_FDERIV 3'h4
`define ACT_CALC_FSTPT 3'h5
`define ACT_STG_IDLE 3'h0
`define ACT_STG_CONV1 3'h3
`define ACT_STG_CONV2 3'h7
`define ACT_CNT_MAX 8'hFF
`define ACT_LJ_SHIFT 6
`define ACT_RST8 8'h00
`define ACT_RST16 16'h0000
`define ACT_RST32 32'h0000_0000

`endif

/* File: hw/act_pkg.sv */
// Purpose: Types for the ADC computation and threshold unit
// Assumes: Constants live in act_defs.svh
// Notes: Sequencer states follow a Gray path idle-conv-calc-test
package act_pkg;

  typedef enum logic [1:0] {
    ACT_IDLE = 2'h0,
    ACT_CONV = 2'h1,
    ACT_CALC = 2'h3,
    ACT_TEST = 2'h2
  } act_state_e;

  typedef struct packed {
    logic enable;
    logic clk_sel;
    logic [5:0] clk_div;
    logic precharge_pol;
    logic guard_pol;
    logic [2:0] stage;
  } act_core_ctl_s;

endpackage

/* File: hw/act_unit.sv */
// Purpose: Post-conversion accumulate, filter, error and threshold logic
// Assumes: APB slave, zero wait states, converter answers with conv_done
// Notes: One conversion per conv_start pulse; double sample uses two
`timescale 1ns/10ps
`include "act_defs.svh"

module act_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output act_pkg::act_core_ctl_s core_ctl,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [9:0] conv_data
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl0, ctrl1, comp, thrc, clk_div, rpt, cnt;
  logic [15:0] res, prev, acc, fltr, stpt, uth, lth, err, first;
  logic ovf, above, below, math, tif, second;
  act_pkg::act_state_e state;

  logic wr, setup, hit;
  logic [2:0] mode, shift, calc, tmd;
  assign wr = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign mode = comp[2:0];
  assign shift = comp[6:4];
  assign calc = thrc[6:4];
  assign tmd = thrc[2:0];

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic dsen, go, cont, pair_first;
  logic signed [16:0] s_val, add, acc_sum, err_wide;
  logic signed [15:0] acc_next, acc_s;
  logic [7:0] cnt_next;
  logic test_en, cond, tif_hit, retrig;
  assign dsen = ctrl1[`ACT_B_DSEN];
  assign go = ctrl0[`ACT_B_GO];
  assign cont = ctrl0[`ACT_B_CONT];
  assign pair_first = dsen & ~second;
  assign acc_s = $signed(acc);

  always_comb begin
    // Double sample pair nets S2-S1 by undoing the first sample here
    if (dsen & second) begin
      s_val = $signed({1'b0, res}) - $signed({1'b0, first}) - $signed({1'b0, first});
    end else begin
      s_val = $signed({1'b0, pair_first ? first : res});
    end
    add = s_val;
    acc_sum = {acc_s[15], acc_s};
    cnt_next = cnt;
    case (mode)
      `ACT_MD_ACC: begin
        add = s_val >>> shift;
        acc_sum = {acc_s[15], acc_s} + add;
        if (~pair_first && cnt != `ACT_CNT_MAX) begin
          cnt_next = cnt + 8'h01;
        end
      end
      `ACT_MD_AVG, `ACT_MD_BURST: begin
        if (~pair_first && cnt >= rpt) begin
          acc_sum = s_val; // restart a new average
          cnt_next = 8'h01;
        end else begin
          acc_sum = {acc_s[15], acc_s} + s_val;
          if (~pair_first) begin
            cnt_next = cnt + 8'h01;
          end
        end
      end
      `ACT_MD_LPF: begin
        acc_sum = {acc_s[15], acc_s} + s_val - ({acc_s[15], acc_s} >>> shift);
        if (~pair_first && cnt != `ACT_CNT_MAX) begin
          cnt_next = cnt + 8'h01;
        end
      end
      default: begin
        acc_sum = {acc_s[15], acc_s};
      end
    endcase
    acc_next = acc_sum[15:0];
  end

  always_comb begin
    // Error uses the freshly updated filtered value
    case (calc)
      `ACT_CALC_DERIV: err_wide = $signed({1'b0, res}) - $signed({1'b0, prev});
      `ACT_CALC_RSTPT: err_wide = (dsen ? $signed({1'b0, res}) - $signed({1'b0, prev})
                                        : $signed({1'b0, res})) - $signed({stpt[15], stpt});
      `ACT_CALC_RFLT: err_wide = (dsen ? $signed({1'b0, res}) - $signed({1'b0, prev})
                                       : $signed({1'b0, res})) - $signed({fltr[15], fltr});
      `ACT_CALC_FDERIV: err_wide = $signed({1'b0, prev}) - $signed({fltr[15], fltr});
      `ACT_CALC_FSTPT: err_wide = $signed({fltr[15], fltr}) - $signed({stpt[15], stpt});
      default: err_wide = 17'sh0_0000;
    endcase
  end

  logic signed [15:0] e16;
  logic err_ovf;
  assign e16 = err_wide[15:0];
  assign err_ovf = err_wide[16] ^ err_wide[15];

  always_comb begin
    case (tmd)
      3'h1: cond = e16 < $signed(lth);
      3'h2: cond = e16 >= $signed(lth);
      3'h3: cond = (e16 >= $signed(lth)) && (e16 <= $signed(uth));
      3'h4: cond = (e16 < $signed(lth)) || (e16 > $signed(uth));
      3'h5: cond = e16 <= $signed(uth);
      3'h6: cond = e16 > $signed(uth);
      3'h7: cond = 1'b1;
      default: cond = 1'b0;
    endcase
  end

  always_comb begin
    case (mode)
      `ACT_MD_ACC: test_en = ~pair_first;
      `ACT_MD_AVG, `ACT_MD_BURST, `ACT_MD_LPF: test_en = ~pair_first && cnt >= rpt;
      default: test_en = 1'b0;
    endcase
  end

  assign tif_hit = test_en & (cond | ovf | err_ovf);
  // Burst keeps going by itself; continuous stops on flag only with stop-on-interrupt
  assign retrig = go & ((cont & ~(thrc[`ACT_B_SOI] & tif_hit))
                  | (mode == `ACT_MD_BURST && cnt < rpt));

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= act_pkg::ACT_IDLE;
    end else begin
      case (state)
        act_pkg::ACT_IDLE: begin
          if (go & ctrl0[`ACT_B_ON]) begin
            state <= act_pkg::ACT_CONV;
          end
        end
        act_pkg::ACT_CONV: begin
          if (conv_done) begin
            state <= act_pkg::ACT_CALC;
          end
        end
        act_pkg::ACT_CALC: state <= act_pkg::ACT_TEST;
        act_pkg::ACT_TEST: state <= act_pkg::ACT_IDLE;
        default: state <= act_pkg::ACT_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= (state == act_pkg::ACT_IDLE) & go & ctrl0[`ACT_B_ON];
    end
  end

  // Which half of a double-sample pair is in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second <= 1'b0;
    end else if (~dsen) begin
      second <= 1'b0;
    end else if (state == act_pkg::ACT_TEST) begin
      second <= ~second;
    end
  end

  // ----------------------------------------------------------------
  // Results, previous value, first sample
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res <= `ACT_RST16;
      prev <= `ACT_RST16;
      first <= `ACT_RST16;
    end else begin
      if (state == act_pkg::ACT_IDLE && go && ~dsen && ctrl0[`ACT_B_ON]) begin
        prev <= comp[`ACT_B_PSIS] ? res : fltr;
      end
      if (state == act_pkg::ACT_CONV && conv_done) begin
        if (pair_first) begin
          first <= {6'h00, conv_data};
        end else begin
          res <= {6'h00, conv_data};
          if (dsen) begin
            prev <= comp[`ACT_B_PSIS] ? first : fltr;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, count, filtered value, overflow
  // ----------------------------------------------------------------
  logic aclr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= `ACT_RST16;
      cnt <= `ACT_RST8;
      fltr <= `ACT_RST16;
      ovf <= 1'b0;
    end else if (aclr) begin
      acc <= `ACT_RST16;
      cnt <= `ACT_RST8;
      ovf <= 1'b0;
    end else if (state == act_pkg::ACT_CALC && mode != `ACT_MD_BASIC) begin
      acc <= acc_next;
      cnt <= cnt_next;
      fltr <= 16'(acc_next >>> shift);
      if (acc_sum[16] ^ acc_sum[15]) begin
        ovf <= 1'b1;
      end
    end else if (state == act_pkg::ACT_TEST && test_en && err_ovf) begin
      ovf <= 1'b1;
    end
  end

  // Clear command lasts one cycle, then reads back as done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aclr <= 1'b0;
    end else begin
      aclr <= wr && paddr == `ACT_OFF_COMP && pwdata[`ACT_B_ACLR];
    end
  end

  // ----------------------------------------------------------------
  // Error value and threshold flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= `ACT_RST16;
      above <= 1'b0;
      below <= 1'b0;
    end else if (state == act_pkg::ACT_TEST && test_en) begin
      err <= e16;
      above <= e16 > $signed(uth);
      below <= e16 < $signed(lth);
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tif <= 1'b0;
    end else if (state == act_pkg::ACT_TEST && tif_hit) begin
      tif <= 1'b1;
    end else if (wr && paddr == `ACT_OFF_TIF && pwdata[`ACT_B_TIF]) begin
      tif <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      math <= 1'b0;
    end else if (state == act_pkg::ACT_CALC && mode != `ACT_MD_BASIC) begin
      math <= 1'b1;
    end else if (wr && paddr == `ACT_OFF_STAT && pwdata[`ACT_B_MATH]) begin
      math <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0 <= `ACT_RST8;
    end else if (wr && paddr == `ACT_OFF_CTRL0) begin
      ctrl0 <= pwdata[7:0] & 8'hD5;
    end else if (state == act_pkg::ACT_TEST && ~retrig) begin
      ctrl0[`ACT_B_GO] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1 <= `ACT_RST8;
      comp <= `ACT_RST8;
      thrc <= `ACT_RST8;
      stpt <= `ACT_RST16;
      uth <= `ACT_RST16;
      lth <= `ACT_RST16;
      rpt <= `ACT_RST8;
      clk_div <= `ACT_RST8;
    end else if (wr) begin
      case (paddr)
        `ACT_OFF_CTRL1: ctrl1 <= pwdata[7:0] & 8'hE1;
        `ACT_OFF_COMP: comp <= pwdata[7:0] & 8'hF7;
        `ACT_OFF_THRC: thrc <= pwdata[7:0] & 8'h7F;
        `ACT_OFF_STPT: stpt <= pwdata[15:0];
        `ACT_OFF_UTH: uth <= pwdata[15:0];
        `ACT_OFF_LTH: lth <= pwdata[15:0];
        `ACT_OFF_RPT: rpt <= pwdata[7:0];
        `ACT_OFF_CLK: clk_div <= pwdata[7:0] & 8'h3F;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Converter core controls
  // ----------------------------------------------------------------
  logic flip;
  assign flip = dsen & ctrl1[`ACT_B_IPEN] & second;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ctl <= '0;
    end else begin
      core_ctl.enable <= ctrl0[`ACT_B_ON];
      core_ctl.clk_sel <= ctrl0[`ACT_B_CS];
      core_ctl.clk_div <= clk_div[5:0];
      core_ctl.precharge_pol <= ctrl1[`ACT_B_PPOL] ^ flip;
      core_ctl.guard_pol <= ctrl1[`ACT_B_GPOL] ^ flip;
      if (state == act_pkg::ACT_CONV) begin
        core_ctl.stage <= second ? `ACT_STG_CONV2 : `ACT_STG_CONV1;
      end else begin
        core_ctl.stage <= `ACT_STG_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB read path, registered in the setup cycle
  // ----------------------------------------------------------------
  logic [15:0] res_out, prev_out;
  logic [31:0] rd;
  assign res_out = ctrl0[`ACT_B_FRM] ? res : 16'(res << `ACT_LJ_SHIFT);
  assign prev_out = ctrl0[`ACT_B_FRM] ? prev : 16'(prev << `ACT_LJ_SHIFT);

  always_comb begin
    rd = `ACT_RST32;
    hit = 1'b1;
    case (paddr)
      `ACT_OFF_CTRL0: rd = {24'h00_0000, ctrl0};
      `ACT_OFF_CTRL1: rd = {24'h00_0000, ctrl1};
      `ACT_OFF_COMP: rd = {24'h00_0000, comp[7:4], aclr, comp[2:0]};
      `ACT_OFF_THRC: rd = {24'h00_0000, thrc};
      `ACT_OFF_STAT: rd = {24'h00_0000, ovf, above, below, math, 1'b0, core_ctl.stage};
      `ACT_OFF_RES: rd = {16'h0000, res_out};
      `ACT_OFF_PREV: rd = {16'h0000, prev_out};
      `ACT_OFF_ACC: rd = {16'h0000, acc};
      `ACT_OFF_FLTR: rd = {16'h0000, fltr};
      `ACT_OFF_STPT: rd = {16'h0000, stpt};
      `ACT_OFF_UTH: rd = {16'h0000, uth};
      `ACT_OFF_LTH: rd = {16'h0000, lth};
      `ACT_OFF_ERR: rd = {16'h0000, err};
      `ACT_OFF_RPT: rd = {24'h00_0000, rpt};
      `ACT_OFF_CNT: rd = {24'h00_0000, cnt};
      `ACT_OFF_CLK: rd = {24'h00_0000, clk_div};
      `ACT_OFF_TIF: rd = {31'h0000_0000, tif};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `ACT_RST32;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? `ACT_RST32 : rd;
      pslverr <= ~hit;
    end
  end

  assign pready = 1'b1;

endmodule

/* File: test/act_unit_sva.sv */
// Purpose: Port-level checks for act_unit
// Assumes: Control bits rebuilt from APB writes seen at the ports
// Notes: core_ctl enable, clock select and polarities are compared only after three quiet cycles
`timescale 1ns/10ps
`include "act_defs.svh"
module act_unit_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire act_pkg::act_core_ctl_s core_ctl,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [9:0] conv_data
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Control shadows
  // ----------------------------------------------------------------
  logic wr_ok;
  logic [7:0] c0;
  logic [7:0] c1;
  logic [1:0] quiet;
  assign wr_ok = psel && penable && pwrite && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0 <= 8'h00;
      c1 <= 8'h00;
    end else if (wr_ok && paddr == `ACT_OFF_CTRL0) begin
      c0 <= pwdata[7:0];
    end else if (wr_ok && paddr == `ACT_OFF_CTRL1) begin
      c1 <= pwdata[7:0];
    end
  end
  // Registered control may lag a write, so give it time to settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet <= 2'h3;
    end else if (wr_ok && (paddr == `ACT_OFF_CTRL0 || paddr == `ACT_OFF_CTRL1)) begin
      quiet <= 2'h0;
    end else if (quiet != 2'h3) begin
      quiet <= quiet + 2'h1;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_enable_follow: assert property (quiet == 2'h3 |-> core_ctl.enable == c0[`ACT_B_ON])
    else $error("converter enable does not follow control");
  a_clock_select: assert property (quiet == 2'h3 |-> core_ctl.clk_sel == c0[`ACT_B_CS])
    else $error("clock select does not follow control");
  a_start_enabled: assert property (conv_start |-> c0[`ACT_B_ON] ##[0:1] core_ctl.stage != 3'h0)
    else $error("conversion started while disabled or idle");
  a_pol_first: assert property (quiet == 2'h3 && core_ctl.stage == 3'h3 |->
    core_ctl.precharge_pol == c1[`ACT_B_PPOL] && core_ctl.guard_pol == c1[`ACT_B_GPOL])
    else $error("first cycle polarity wrong");
  a_pol_second: assert property (quiet == 2'h3 && core_ctl.stage == 3'h7 |->
    core_ctl.precharge_pol == (c1[`ACT_B_PPOL] ^ c1[`ACT_B_IPEN]) &&
    core_ctl.guard_pol == (c1[`ACT_B_GPOL] ^ c1[`ACT_B_IPEN]))
    else $error("second cycle polarity wrong");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion request longer than one cycle");
  a_done_gap: assert property (conv_done |=> !conv_start [*3])
    else $error("new conversion before result was processed");
  a_return_idle: assert property (conv_done |-> ##[1:3] core_ctl.stage == 3'h0)
    else $error("sequencer did not leave conversion stage");
  a_unmapped_err: assert property (psel && penable && paddr > `ACT_OFF_TIF |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && paddr <= `ACT_OFF_TIF && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  c_double: cover property (conv_done && core_ctl.stage == 3'h7);
  c_retrig: cover property (conv_done ##[3:6] conv_start);
  c_refused: cover property (psel && penable && pslverr);
endmodule

/* File: test/act_conv_model.sv */
// Purpose: Behavioural converter core facing act_unit
// Assumes: One conversion per start pulse, latency set by the bench
// Notes: Data line toggles outside the done pulse so stale values never match
`timescale 1ns/10ps
module act_conv_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conv_start,
  input wire logic [9:0] sample,
  input wire logic [3:0] lat,
  output logic conv_done,
  output logic [9:0] conv_data
);
  logic busy;
  logic [3:0] left;
  // Each start gets exactly one answer, so the two halves of a pair are separate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      left <= 4'h0;
      conv_done <= 1'b0;
      conv_data <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        busy <= 1'b1;
        left <= lat;
      end else if (busy && left == 4'h0) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= sample;
      end else if (busy) begin
        left <= left - 4'h1;
      end
    end
  end
endmodule

/* File: test/act_unit_bench.sv */
// Purpose: Self-checking bench for act_unit
// Assumes: Zero wait APB slave, converter model answers each start
// Notes: Reads queue their expectation; a monitor compares at the access edge
`timescale 1ns/10ps
`include "act_defs.svh"
module act_unit_bench;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
  } act_note_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_start, conv_done, lt, gt;
  logic [7:0] paddr, hits;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] conv_data, sample, s, s2;
  logic [3:0] lat;
  act_pkg::act_core_ctl_s core_ctl;
  act_note_s nt;
  act_note_s notes[$];
  int checks, n_mismatch, n_start, i, t, k, n0, sum;
  int errs [5];
  always #2 pclk = ~pclk;
  act_unit act_unit_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_ctl(core_ctl), .conv_start(conv_start), .conv_done(conv_done),
    .conv_data(conv_data));
  act_conv_model act_conv_model_inst (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .sample(sample), .lat(lat), .conv_done(conv_done), .conv_data(conv_data));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      nt = notes.pop_front();
      check(prdata & nt.m, nt.d);
      check({31'h0, pslverr}, {31'h0, nt.e});
    end
    if (conv_start === 1'b1) begin
      n_start <= n_start + 1;
    end
  end
  // ----------------------------------------------------------------
  // Bus and conversion tasks
  // ----------------------------------------------------------------
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e & m, m, a > `ACT_OFF_TIF});
    xfer(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic waitgo(input int bound);
    int n;
    n = 0;
    rdc(`ACT_OFF_CTRL0, 32'h0000_0001, 32'h0000_0001);
    while (rd[0] !== 1'b0 && n < bound) begin
      rdc(`ACT_OFF_CTRL0, 32'h0000_0000, 32'h0000_0000);
      n++;
    end
    if (rd[0] !== 1'b0) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic conv(input logic [9:0] v, input logic [31:0] c);
    sample <= v;
    lat <= 4'($urandom_range(12, 1));
    wr(`ACT_OFF_CTRL0, c);
    waitgo(100);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sample = 10'h000;
    lat = 4'h1;
    errs = '{-8, -4, 0, 4, 9};
    k = $urandom(32'h92CE_EBE2);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i <= 68; i += 4) begin
      rdc(8'(i), 32'h0000_0000, 32'hFFFF_FFFF);
    end
    wr(`ACT_OFF_THRC, 32'h0000_0007);
    s = 10'($urandom);
    conv(s, 32'h0000_0095);
    rdc(`ACT_OFF_RES, {22'h0, s}, 32'h0000_FFFF);
    rdc(`ACT_OFF_ACC, 32'h0000_0000, 32'h0000_FFFF);
    rdc(`ACT_OFF_TIF, 32'h0000_0000, 32'h0000_0001);
    rdc(`ACT_OFF_CTRL0, 32'h0000_0094, 32'h0000_00FF);
    wr(`ACT_OFF_CTRL0, 32'h0000_0080);
    rdc(`ACT_OFF_RES, {16'h0, s, 6'h0}, 32'h0000_FFFF);
    // Left-justified setting must not disturb the accumulator
    wr(`ACT_OFF_COMP, 32'h0000_0009);
    sum = 0;
    for (i = 0; i < 3; i++) begin
      s = 10'($urandom);
      sum += int'(s);
      conv(s, 32'h0000_0081);
      rdc(`ACT_OFF_TIF, 32'h0000_0001, 32'h0000_0001);
      wr(`ACT_OFF_TIF, 32'h0000_0001);
    end
    rdc(`ACT_OFF_ACC, 32'(sum), 32'h0000_FFFF);
    rdc(`ACT_OFF_CNT, 32'h0000_0003, 32'h0000_00FF);
    wr(`ACT_OFF_COMP, 32'h0000_0009);
    rdc(`ACT_OFF_COMP, 32'h0000_0001, 32'h0000_00FF);
    rdc(`ACT_OFF_ACC, 32'h0000_0000, 32'h0000_FFFF);
    rdc(`ACT_OFF_CNT, 32'h0000_0000, 32'h0000_00FF);
    wr(`ACT_OFF_RPT, 32'h0000_0003);
    wr(`ACT_OFF_THRC, 32'h0000_0056);
    wr(`ACT_OFF_COMP, 32'h0000_000A);
    s = 10'($urandom) | 10'h001;
    conv(s, 32'h0000_0085);
    rdc(`ACT_OFF_TIF, 32'h0000_0000, 32'h0000_0001);
    wr(`ACT_OFF_COMP, 32'h0000_001B);
    n0 = n_start;
    conv(s, 32'h0000_0085);
    check(32'(n_start - n0), 32'h0000_0003);
    sum = 3 * int'(s);
    rdc(`ACT_OFF_ACC, 32'(sum), 32'h0000_FFFF);
    rdc(`ACT_OFF_CNT, 32'h0000_0003, 32'h0000_00FF);
    rdc(`ACT_OFF_FLTR, 32'(sum >> 1), 32'h0000_FFFF);
    rdc(`ACT_OFF_ERR, 32'(sum >> 1), 32'h0000_FFFF);
    rdc(`ACT_OFF_TIF, 32'h0000_0001, 32'h0000_0001);
    wr(`ACT_OFF_UTH, 32'h0000_0005);
    wr(`ACT_OFF_LTH, 32'h0000_FFFB);
    for (t = 0; t < 8; t++) begin
      k = errs[$urandom_range(4, 0)];
      s = 10'($urandom_range(1000, 20));
      lt = k < -5;
      gt = k > 5;
      hits = {1'b1, gt, !gt, lt || gt, !lt && !gt, !lt, lt, 1'b0};
      wr(`ACT_OFF_TIF, 32'h0000_0001);
      wr(`ACT_OFF_COMP, 32'h0000_0009);
      wr(`ACT_OFF_THRC, 32'h0000_0010 | t);
      wr(`ACT_OFF_STPT, 32'(int'(s) - k));
      conv(s, 32'h0000_0085);
      rdc(`ACT_OFF_ERR, 32'(k), 32'h0000_FFFF);
      rdc(`ACT_OFF_STAT, {25'h0, gt, lt, 5'h0}, 32'h0000_0060);
      rdc(`ACT_OFF_TIF, {31'h0, hits[t]}, 32'h0000_0001);
    end
    wr(`ACT_OFF_TIF, 32'h0000_0001);
    wr(`ACT_OFF_COMP, 32'h0000_0009);
    wr(`ACT_OFF_THRC, 32'h0000_0000);
    for (i = 0; i < 33; i++) begin
      conv(10'h3FF, 32'h0000_0085);
    end
    rdc(`ACT_OFF_STAT, 32'h0000_0080, 32'h0000_0080);
    rdc(`ACT_OFF_TIF, 32'h0000_0001, 32'h0000_0001);
    wr(`ACT_OFF_COMP, 32'h0000_0009);
    wr(`ACT_OFF_STPT, 32'h0000_0000);
    wr(`ACT_OFF_UTH, 32'h0000_01F4);
    wr(`ACT_OFF_THRC, 32'h0000_001E);
    wr(`ACT_OFF_TIF, 32'h0000_0001);
    sample <= 10'h064;
    n0 = n_start;
    wr(`ACT_OFF_CTRL0, 32'h0000_00C5);
    k = 0;
    while (n_start - n0 < 3 && k < 300) begin
      @(posedge pclk);
      k++;
    end
    check({31'h0, k < 300}, 32'h0000_0001);
    sample <= 10'h384;
    waitgo(300);
    rdc(`ACT_OFF_CNT, 32'(n_start - n0), 32'h0000_00FF);
    rdc(`ACT_OFF_TIF, 32'h0000_0001, 32'h0000_0001);
    wr(`ACT_OFF_CTRL1, 32'h0000_00E1);
    wr(`ACT_OFF_COMP, 32'h0000_0089);
    wr(`ACT_OFF_THRC, 32'h0000_0007);
    wr(`ACT_OFF_TIF, 32'h0000_0001);
    wr(`ACT_OFF_STAT, 32'h0000_0010);
    s = 10'($urandom);
    s2 = 10'($urandom);
    conv(s, 32'h0000_0085);
    rdc(`ACT_OFF_TIF, 32'h0000_0000, 32'h0000_0001);
    rdc(`ACT_OFF_STAT, 32'h0000_0010, 32'h0000_0010);
    conv(s2, 32'h0000_0085);
    sum = int'(s2) - int'(s);
    rdc(`ACT_OFF_RES, {22'h0, s2}, 32'h0000_FFFF);
    rdc(`ACT_OFF_PREV, {22'h0, s}, 32'h0000_FFFF);
    rdc(`ACT_OFF_ERR, 32'(sum), 32'h0000_FFFF);
    rdc(`ACT_OFF_ACC, 32'(sum), 32'h0000_FFFF);
    rdc(`ACT_OFF_TIF, 32'h0000_0001, 32'h0000_0001);
    wr(`ACT_OFF_COMP, 32'h0000_001C);
    conv(s, 32'h0000_0085);
    rdc(`ACT_OFF_FLTR, 32'(s >> 1), 32'h0000_FFFF);
    end_sim();
  end
endmodule
bind act_unit act_unit_sva act_unit_sva_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .core_ctl(core_ctl), .conv_start(conv_start),
  .conv_done(conv_done), .conv_data(conv_data));
